// file: common/dasr_pkg.sv
package dasr_pkg;

  // Result word and conversion framing
  localparam int unsigned RESULT_W       = 12;
  localparam int unsigned LEAD_ZEROS     = 4;
  localparam int unsigned FALLS_PER_CONV = LEAD_ZEROS + RESULT_W;
  localparam int unsigned ACQ_CYCLES     = 3;
  localparam int unsigned CNT_W          = 5;
  localparam int unsigned FIFO_DEPTH     = 4;

  localparam logic [CNT_W-1:0] CNT_IDLE  = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST  = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ACQ   = 5'h03;
  localparam logic [CNT_W-1:0] CNT_LEAD  = 5'h04;

  // Two's complement codes at the ends and the middle of the range
  localparam logic [RESULT_W-1:0] CODE_POS_FULL  = 12'h7FF;
  localparam logic [RESULT_W-1:0] CODE_ZERO      = 12'h000;
  localparam logic [RESULT_W-1:0] CODE_MINUS_ONE = 12'hFFF;
  localparam logic [RESULT_W-1:0] CODE_NEG_FULL  = 12'h800;

  // Pin levels after reset: select idle high, serial clock idle low
  localparam logic CS_N_RST = 1'b1;
  localparam logic SCLK_RST = 1'b0;

  // Burst pacing figures for the host side
  localparam int unsigned BURST_SCLK_HZ   = 16000000;
  localparam int unsigned BURST_BELOW_SPS = 500000;
  localparam int unsigned MCLK_HZ         = 200000000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV  = 3'b100
  } dasr_state_e;

endpackage : dasr_pkg

// file: design/dasr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module dasr_fifo #(
  parameter int unsigned W     = 12,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
    logic                    not_full;
    logic                    not_empty;
  } dasr_fifo_s;

  dasr_fifo_s q;
  dasr_fifo_s d;
  logic       push;
  logic       pop;

  assign push        = in_valid_i & q.not_full;
  assign pop         = out_ready_i & q.not_empty;
  assign in_ready_o  = q.not_full;
  assign out_valid_o = q.not_empty;
  assign out_data_o  = q.mem[q.rd_ptr];

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr_ptr] = in_data_i;
      d.wr_ptr        = (q.wr_ptr == LAST_PTR) ? '0 : q.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      d.rd_ptr = (q.rd_ptr == LAST_PTR) ? '0 : q.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      d.count = q.count + 1'b1;
    end
    else if (pop && !push)
    begin
      d.count = q.count - 1'b1;
    end
    // Flags registered together with the count
    d.not_full  = (d.count != FULL_CNT);
    d.not_empty = (d.count != '0);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q           <= '0;
      q.not_full  <= 1'b1;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

endmodule : dasr_fifo

`default_nettype wire

// file: design/dasr_readout.sv
`timescale 1ns/1ps
`default_nettype none

module dasr_readout (
  input  wire logic                           mclk_i,
  input  wire logic                           rst_i,
  input  wire logic                           ce_i,
  input  wire logic                           cs_n_i,
  input  wire logic                           sclk_i,
  output logic                                dout_o,
  output logic                                dout_oe_o,
  output logic                                pwr_down_o,
  output logic                                acq_o,
  output logic                                abort_o,
  output logic                                conv_done_o,
  output logic                                underrun_o,
  input  wire logic [dasr_pkg::RESULT_W-1:0]  sample_data_i,
  input  wire logic                           sample_valid_i,
  output logic                                sample_ready_o
);
  import dasr_pkg::*;

  // Whole state, synchronisers included
  typedef struct packed {
    logic                cs_m;
    logic                cs_s;
    logic                cs_p;
    logic                sclk_m;
    logic                sclk_s;
    logic                sclk_p;
    dasr_state_e         st;
    logic [CNT_W-1:0]    cnt;
    logic [RESULT_W-1:0] word;
    logic                dout;
    logic                oe;
    logic                pwr_dn;
    logic                acq;
    logic                abort;
    logic                done;
    logic                underrun;
  } dasr_rd_s;

  dasr_rd_s            q;
  dasr_rd_s            d;
  logic                cs_fall;
  logic                cs_rise;
  logic                sclk_fall;
  logic                pop;
  logic [RESULT_W-1:0] fifo_data;
  logic                at_last;
  logic                fifo_valid;

  // Falls one to four put leading zeros on the line
  function automatic logic in_lead(input logic [CNT_W-1:0] n);
    in_lead = (n <= CNT_LEAD);
  endfunction : in_lead

  // Falls one to three keep the input in acquisition
  function automatic logic in_acq(input logic [CNT_W-1:0] n);
    in_acq = (n <= CNT_ACQ);
  endfunction : in_acq

  // Bit on the line after falling edge n of a conversion
  function automatic logic out_bit(input logic [CNT_W-1:0]    n,
                                   input logic [RESULT_W-1:0] w);
    logic [CNT_W-1:0] idx;
    idx = CNT_LAST - n;
    if (in_lead(n))
    begin
      out_bit = 1'b0;
    end
    else
    begin
      out_bit = w[idx[3:0]];
    end
  endfunction : out_bit

  // Word for a new conversion, the held one on underrun
  function automatic logic [RESULT_W-1:0] next_word(input logic                avail,
                                                   input logic [RESULT_W-1:0] fresh,
                                                   input logic [RESULT_W-1:0] held);
    if (avail)
    begin
      next_word = fresh;
    end
    else
    begin
      next_word = held;
    end
  endfunction : next_word

  // Falling level between two synchroniser stages
  function automatic logic went_low(input logic older,
                                    input logic newer);
    went_low = older & ~newer;
  endfunction : went_low

  // Rising level between two synchroniser stages
  function automatic logic went_high(input logic older,
                                     input logic newer);
    went_high = ~older & newer;
  endfunction : went_high

  // Samples wait here until a conversion opens
  dasr_fifo #(
    .W     (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (sample_data_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop)
  );

  // Edges seen on the second synchroniser stage only
  assign cs_fall   = went_low(q.cs_p, q.cs_s);
  assign cs_rise   = went_high(q.cs_p, q.cs_s);
  assign sclk_fall = went_low(q.sclk_p, q.sclk_s);

  // Conversion count at its sixteenth fall
  assign at_last   = (q.cnt == CNT_LAST);

  always_comb
  begin
    d          = q;
    pop        = 1'b0;
    d.abort    = 1'b0;
    d.done     = 1'b0;
    d.underrun = 1'b0;
    d.cs_m     = cs_n_i;
    d.cs_s     = q.cs_m;
    d.cs_p     = q.cs_s;
    d.sclk_m   = sclk_i;
    d.sclk_s   = q.sclk_m;
    d.sclk_p   = q.sclk_s;
    case (q.st)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          d.oe     = 1'b1;
          d.pwr_dn = 1'b0;
          d.dout   = 1'b0;
          // Select fell on a high clock: wait for its fall
          d.st     = ST_ARMED;
          if (!q.sclk_s)
          begin
            // Select fall counts as falling edge one
            d.st  = ST_CONV;
            d.cnt = CNT_FIRST;
            d.acq = 1'b1;
            pop   = fifo_valid;
            d.underrun = ~fifo_valid;
            d.word = next_word(fifo_valid, fifo_data, q.word);
            d.dout = out_bit(CNT_FIRST, d.word);
          end
        end
        else
        begin
          // Select high: powered down, pin released
          d.oe     = 1'b0;
          d.pwr_dn = 1'b1;
          d.dout   = 1'b0;
          d.acq    = 1'b0;
          d.cnt    = CNT_IDLE;
        end
      end
      ST_ARMED:
      begin
        if (cs_rise)
        begin
          d.st     = ST_IDLE;
          d.oe     = 1'b0;
          d.pwr_dn = 1'b1;
          d.dout   = 1'b0;
          d.abort  = 1'b1;
        end
        else if (sclk_fall)
        begin
          d.st  = ST_CONV;
          d.cnt = CNT_FIRST;
          d.acq = 1'b1;
          pop   = fifo_valid;
          d.underrun = ~fifo_valid;
          d.word = next_word(fifo_valid, fifo_data, q.word);
          d.dout = out_bit(CNT_FIRST, d.word);
        end
        else
        begin
          // Waiting for the first clock fall, line held low
          d.dout = 1'b0;
          d.acq  = 1'b0;
        end
      end
      ST_CONV:
      begin
        if (cs_rise)
        begin
          // Frame end, early rise abandons the conversion
          d.st     = ST_IDLE;
          d.oe     = 1'b0;
          d.pwr_dn = 1'b1;
          d.dout   = 1'b0;
          d.acq    = 1'b0;
          d.abort  = ~at_last;
          d.cnt    = CNT_IDLE;
        end
        else if (sclk_fall)
        begin
          if (at_last)
          begin
            // Next conversion in the same frame
            d.cnt = CNT_FIRST;
            pop   = fifo_valid;
            d.underrun = ~fifo_valid;
            d.word = next_word(fifo_valid, fifo_data, q.word);
          end
          else
          begin
            d.cnt = q.cnt + 1'b1;
          end
          d.acq  = in_acq(d.cnt);
          d.dout = out_bit(d.cnt, d.word);
          // Sixteenth fall ends the conversion
          d.done = (d.cnt == CNT_LAST);
        end
      end
      default:
      begin
        // Stray state code: back to the idle picture
        d.word   = CODE_ZERO;
        d.st     = ST_IDLE;
        d.oe     = 1'b0;
        d.pwr_dn = 1'b1;
        d.dout   = 1'b0;
        d.acq    = 1'b0;
        d.cnt    = CNT_IDLE;
      end
    endcase
  end

  // Reset acts even with the enable low
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q.cs_m     <= CS_N_RST;
      q.cs_s     <= CS_N_RST;
      q.cs_p     <= CS_N_RST;
      q.sclk_m   <= SCLK_RST;
      q.sclk_s   <= SCLK_RST;
      q.sclk_p   <= SCLK_RST;
      q.st       <= ST_IDLE;
      q.cnt      <= CNT_IDLE;
      q.word     <= CODE_ZERO;
      q.dout     <= 1'b0;
      q.oe       <= 1'b0;
      q.pwr_dn   <= 1'b1;
      q.acq      <= 1'b0;
      q.abort    <= 1'b0;
      q.done     <= 1'b0;
      q.underrun <= 1'b0;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  // Outputs come straight from the state register
  assign dout_o      = q.dout;
  assign dout_oe_o   = q.oe;
  assign pwr_down_o  = q.pwr_dn;
  assign acq_o       = q.acq;
  assign abort_o     = q.abort;
  assign conv_done_o = q.done;
  assign underrun_o  = q.underrun;

endmodule : dasr_readout

`default_nettype wire

// file: dv/dasr_readout_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dasr_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic pwr_down_o,
  input wire logic acq_o,
  input wire logic abort_o,
  input wire logic conv_done_o
);
  logic       sclk_q;
  logic [3:0] fell_q;
  // Sclk falls seen at the pin, aged by cycle
  always_ff @(posedge mclk_i)
  begin
    sclk_q <= sclk_i;
    fell_q <= {fell_q[2:0], sclk_q & ~sclk_i};
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_oe_on_select: assert property (
    $fell(cs_n_i) |-> ##[3:4] dout_oe_o && !pwr_down_o) else $error("no drive after select");
  a_oe_off_release: assert property (
    $rose(cs_n_i) |-> ##[3:4] !dout_oe_o && pwr_down_o) else $error("drive after release");
  a_mode_pin_tied: assert property (
    pwr_down_o != dout_oe_o) else $error("mode and enable disagree");
  a_bit_on_fall: assert property (
    $changed(dout_o) && $past(dout_oe_o) && dout_oe_o |-> fell_q[3:2] != 2'b00)
    else $error("data moved without sclk fall");
  a_acq_zeros: assert property (
    acq_o |-> !dout_o) else $error("data bit during acquisition");
  a_acq_span: assert property (
    $rose(acq_o) |-> acq_o [*8]) else $error("acquisition too short");
  a_abort_on_rise: assert property (
    abort_o |-> $past(cs_n_i, 3) && !conv_done_o ##1 !abort_o) else $error("stray abort");
  a_done_single: assert property (
    conv_done_o |=> !conv_done_o && dout_oe_o) else $error("bad done pulse");
  a_idle_quiet: assert property (
    cs_n_i [*6] |-> !dout_oe_o && !acq_o && !conv_done_o) else $error("active while idle");
endmodule : dasr_chk
`default_nettype wire

// file: dv/dasr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dasr_host_model (
  input  wire logic mclk_i,
  input  wire logic dout_pin_i,
  output logic      cs_n_o,
  output logic      sclk_o
);
  logic [15:0] shift_q = '0;
  logic [15:0] rx_q[$];
  realtime     next_t;
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b0;
  // Toggles land on mclk edges, 32 ns apart on average
  task automatic half();
    next_t += 32.0;
    while ($realtime < next_t) @(posedge mclk_i);
  endtask : half
  task automatic frame(input int nfall, input bit hi_start);
    rx_q.delete();
    next_t = $realtime;
    if (hi_start)
    begin
      sclk_o <= 1'b1;
      half();
    end
    cs_n_o <= 1'b0;
    if (hi_start)
    begin
      half();
      sclk_o <= 1'b0;
    end
    for (int i = 1; i <= nfall; i++)
    begin
      half();
      sclk_o <= 1'b1;
      shift_q = {shift_q[14:0], dout_pin_i};
      if (i % 16 == 0) rx_q.push_back(shift_q);
      half();
      if (i < nfall) sclk_o <= 1'b0;
    end
    cs_n_o <= 1'b1;
    half();
    sclk_o <= 1'b0;
    half();
  endtask : frame
endmodule : dasr_host_model
`default_nettype wire

// file: dv/dasr_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dasr_readout_tb_top;
  import dasr_pkg::*;
  logic                mclk_i = 1'b0;
  logic                rst_i  = 1'b1;
  logic [RESULT_W-1:0] sdata  = '0;
  logic                svalid = 1'b0;
  logic                last_q = 1'b0;
  logic                cs_n, sclk, dout, oe, pd, acq, abrt, done, undr, srdy, pin;
  int                  bad_count = 0;
  int                  check_count = 0;
  int                  n_ab = 0;
  int                  n_dn = 0;
  int                  n_un = 0;
  initial forever #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    if (oe === 1'b1) last_q <= dout;
    n_ab += (abrt === 1'b1);
    n_dn += (done === 1'b1);
    n_un += (undr === 1'b1);
  end
  // Released pin must not show the stale bit
  assign pin = (oe === 1'b1) ? dout : ~last_q;
  dasr_readout dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .cs_n_i(cs_n), .sclk_i(sclk),
    .dout_o(dout), .dout_oe_o(oe), .pwr_down_o(pd), .acq_o(acq), .abort_o(abrt),
    .conv_done_o(done), .underrun_o(undr), .sample_data_i(sdata), .sample_valid_i(svalid),
    .sample_ready_o(srdy));
  dasr_host_model host_u (.mclk_i(mclk_i), .dout_pin_i(pin), .cs_n_o(cs_n), .sclk_o(sclk));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic push(input logic [11:0] w);
    sdata <= w;
    svalid <= 1'b1;
    @(posedge mclk_i);
    svalid <= 1'b0;
    @(posedge mclk_i);
  endtask : push
  task automatic t_codes();
    logic [11:0] c[4] = '{CODE_POS_FULL, CODE_ZERO, CODE_MINUS_ONE, CODE_NEG_FULL};
    foreach (c[i]) push(c[i]);
    chk(srdy, 16'h0000, "fifo full");
    push(12'h123);
    n_dn = 0;
    n_ab = 0;
    host_u.frame(64, 1'b0);
    chk(host_u.rx_q.size(), 16'h0004, "word count");
    foreach (c[i]) chk(host_u.rx_q[i], {4'h0, c[i]}, "code");
    chk(n_dn, 16'h0004, "done pulses");
    chk(n_ab, 16'h0000, "abort pulses");
    chk({pd, oe}, 16'h0002, "idle pins");
    $display("test t_codes done");
  endtask : t_codes
  task automatic t_short();
    push(12'h5A3);
    n_ab = 0;
    host_u.frame(8, 1'b1);
    chk(host_u.shift_q[7:0], 16'h0005, "short bits");
    chk(n_ab, 16'h0001, "abort pulses");
    chk({pd, oe}, 16'h0002, "idle pins");
    $display("test t_short done");
  endtask : t_short
  task automatic t_underrun();
    n_ab = 0;
    n_dn = 0;
    n_un = 0;
    host_u.frame(16, 1'b0);
    chk(host_u.rx_q[0], 16'h05A3, "resent word");
    chk(n_un, 16'h0001, "underrun pulses");
    chk(n_dn, 16'h0001, "done pulses");
    chk(n_ab, 16'h0000, "abort pulses");
    $display("test t_underrun done");
  endtask : t_underrun
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    @(posedge mclk_i);
    chk({pd, oe, srdy}, 16'h0005, "reset pins");
    t_codes();
    t_short();
    t_underrun();
    finish_test();
  end
  initial
  begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule : dasr_readout_tb_top
bind dasr_readout dasr_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .pwr_down_o(pwr_down_o),
  .acq_o(acq_o), .abort_o(abort_o), .conv_done_o(conv_done_o));
`default_nettype wire
